// *** common/uab_cfg.svh ***
// Offsets, field positions, counter start value and rates of the autobaud block
// Behaviour
// - Software setting autobaud_start begins a calibration sequence.
// - Receiver state machine is held idle while calibration runs.
// - Remote sends 55h; five rising edges including stop bit start.
// - Counting starts at first rise after start bit, stops at fifth.
// - Fifth rise: count left in divisor pair, start cleared, pending set.
// - Reading receive holding clears receive pending; value is discarded.
// - Divisor pair works as one 16-bit counter during calibration.
// - Counter advances at one eighth of the base divisor clock.
// - Calibration clock: /512, /128 with one select, /32 with both.
// - Base clock: /64, /16 with exactly one select, /4 with both.
// - With wake-on-break set, measurement uses the character after break.
// - Counter starts at 1; software subtracts 1 afterwards.
// - Result equals average bit time in base divisor clock periods.
// - Receive pending is read-only; set at the fifth rise, cleared only by reading receive holding.
`ifndef UAB_CFG_SVH
`define UAB_CFG_SVH
`define UAB_OFF_BAUD_CONTROL 4'h0
`define UAB_OFF_RECEIVE_HOLDING 4'h1
`define UAB_OFF_DIVISOR_LOW 4'h2
`define UAB_OFF_DIVISOR_HIGH 4'h3
`define UAB_OFF_IRQ_STATUS 4'h4
`define UAB_OFF_IRQ_MASK 4'h5
`define UAB_OFF_CONFIG 4'h6
`define UAB_BIT_START 0
`define UAB_BIT_WAKE 1
`define UAB_BIT_WIDE 3
`define UAB_BIT_IDLE 6
`define UAB_BIT_OVF 7
`define UAB_BIT_HSPEED 0
`define UAB_BIT_PEND 1
`define UAB_IRQ_DONE 0
`define UAB_IRQ_OVF 1
`define UAB_DIV_BASE_SLOW 16'h003f
`define UAB_DIV_BASE_MID 16'h000f
`define UAB_DIV_BASE_FAST 16'h0003
`define UAB_ABD_PRESCALE 3'h7
`define UAB_COUNT_START 16'h0001
`define UAB_EDGES 3'h5
`define UAB_SYNC_CHAR 8'h55
`endif

// *** common/uab_pkg.sv ***
// Types shared by the autobaud block
package uab_pkg;
   typedef enum logic [1:0] {
      uab_idle_st,
      uab_wait_break_st,
      uab_wait_start_st,
      uab_measure_st
   } uab_state_type;

   typedef struct packed {
      logic [3:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
   } uab_bus_req_type;

   typedef struct packed {
      logic overflow;
      logic wide;
      logic wake;
      logic start;
   } uab_control_type;
endpackage

// *** hdl/uab_autobaud.sv ***
// Autobaud measurement with Avalon-MM register slave
`timescale 1ns/1ps
`include "uab_cfg.svh"
module uab_autobaud
   import uab_pkg::*;
#(
   parameter int ADDR_WIDTH = 4
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic [ADDR_WIDTH-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic rx_in,
   input wire logic break_seen,
   output logic receiver_idle_hold,
   output logic irq
);
   uab_bus_req_type req;
   uab_control_type ctrl;
   uab_state_type state;
   logic high_speed_divider_select;
   logic receive_pending_flag;
   logic [7:0] receive_holding;
   logic [15:0] divisor;
   logic [15:0] base_count;
   logic [2:0] abd_count;
   logic [2:0] edge_count;
   logic rx_last;
   logic [1:0] irq_status;
   logic [1:0] irq_mask;
   logic accept;
   logic rx_rise;
   logic base_tick;
   logic abd_tick;
   logic finish;
   logic rollover;
   logic [15:0] base_limit;
   logic wr_ctrl;
   logic wr_low;
   logic wr_high;
   logic rd_hold;
   logic rd_status;

   assign req = '{address: avs_address[3:0], read: avs_read,
                  write: avs_write, writedata: avs_writedata};
   // One wait cycle per access so read data come from a flip-flop
   assign accept = (req.read | req.write) & avs_waitrequest == 1'b0;
   assign wr_ctrl = accept & req.write
      & req.address == `UAB_OFF_BAUD_CONTROL;
   assign wr_low = accept & req.write & req.address == `UAB_OFF_DIVISOR_LOW;
   assign wr_high = accept & req.write
      & req.address == `UAB_OFF_DIVISOR_HIGH;
   assign rd_hold = accept & req.read
      & req.address == `UAB_OFF_RECEIVE_HOLDING;
   assign rd_status = accept & req.read & req.address == `UAB_OFF_IRQ_STATUS;

   assign rx_rise = rx_in & ~rx_last;
   assign finish = state == uab_measure_st & rx_rise
      & edge_count == `UAB_EDGES - 3'h1;
   assign rollover = state == uab_measure_st & abd_tick
      & divisor == 16'hffff;

   // Base clock division from the two select bits
   always_comb begin
      unique case ({ctrl.wide, high_speed_divider_select})
         2'b00: base_limit = `UAB_DIV_BASE_SLOW;
         2'b01, 2'b10: base_limit = `UAB_DIV_BASE_MID;
         2'b11: base_limit = `UAB_DIV_BASE_FAST;
      endcase
   end
   // Eighth of base gives /512, /128, /32
   assign base_tick = base_count == base_limit;
   assign abd_tick = base_tick & abd_count == `UAB_ABD_PRESCALE;

   always_ff @(posedge clock) begin
      if (!resetn) begin
         avs_waitrequest <= 1'b1;
      end else if (avs_waitrequest & (req.read | req.write)) begin
         avs_waitrequest <= 1'b0;
      end else begin
         avs_waitrequest <= 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         rx_last <= 1'b1;
      end else begin
         rx_last <= rx_in;
      end
   end

   // Prescalers run only while measuring, so phase starts at the edge
   always_ff @(posedge clock) begin
      if (!resetn || state != uab_measure_st) begin
         base_count <= 16'h0000;
         abd_count <= 3'h0;
      end else if (base_tick) begin
         base_count <= 16'h0000;
         abd_count <= abd_count + 3'h1;
      end else begin
         base_count <= base_count + 16'h0001;
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         state <= uab_idle_st;
         edge_count <= 3'h0;
      end else begin
         unique case (state)
            uab_idle_st: begin
               if (wr_ctrl & avs_writedata[`UAB_BIT_START]) begin
                  state <= avs_writedata[`UAB_BIT_WAKE]
                     ? uab_wait_break_st : uab_wait_start_st;
               end
            end
            uab_wait_break_st: begin
               if (break_seen) begin
                  state <= uab_wait_start_st;
               end
            end
            uab_wait_start_st: begin
               // First rise after the start bit opens the window
               if (rx_rise) begin
                  state <= uab_measure_st;
                  edge_count <= 3'h1;
               end
            end
            uab_measure_st: begin
               if (finish) begin
                  state <= uab_idle_st;
                  edge_count <= 3'h0;
               end else if (rx_rise) begin
                  edge_count <= edge_count + 3'h1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         divisor <= 16'h0000;
      end else if (state == uab_wait_start_st & rx_rise) begin
         divisor <= `UAB_COUNT_START;
      end else if (state == uab_measure_st & abd_tick & ~finish) begin
         // Both bytes always count together; result is bit time
         divisor <= divisor + 16'h0001;
      end else if (state == uab_idle_st) begin
         if (wr_low) begin
            divisor[7:0] <= avs_writedata[7:0];
         end
         if (wr_high) begin
            divisor[15:8] <= avs_writedata[7:0];
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         ctrl <= '0;
         high_speed_divider_select <= 1'b0;
      end else begin
         if (finish) begin
            ctrl.start <= 1'b0;
         end else if (wr_ctrl) begin
            ctrl.start <= avs_writedata[`UAB_BIT_START] | ctrl.start;
         end
         if (wr_ctrl & state == uab_idle_st) begin
            ctrl.wake <= avs_writedata[`UAB_BIT_WAKE];
            ctrl.wide <= avs_writedata[`UAB_BIT_WIDE];
         end
         // Set wins over a software clear
         if (rollover) begin
            ctrl.overflow <= 1'b1;
         end else if (wr_ctrl) begin
            ctrl.overflow <= avs_writedata[`UAB_BIT_OVF];
         end
         if (accept & req.write & req.address == `UAB_OFF_CONFIG) begin
            high_speed_divider_select <= avs_writedata[`UAB_BIT_HSPEED];
         end
      end
   end

   // Pending flag has no write path from software
   always_ff @(posedge clock) begin
      if (!resetn) begin
         receive_pending_flag <= 1'b0;
         receive_holding <= 8'h00;
      end else if (finish) begin
         receive_pending_flag <= 1'b1;
         receive_holding <= `UAB_SYNC_CHAR;
      end else if (rd_hold) begin
         receive_pending_flag <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         receiver_idle_hold <= 1'b0;
      end else begin
         receiver_idle_hold <= ctrl.start | (wr_ctrl
            & avs_writedata[`UAB_BIT_START]);
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         irq_status <= 2'b00;
         irq_mask <= 2'b00;
      end else begin
         irq_status[`UAB_IRQ_DONE] <= finish
            | (irq_status[`UAB_IRQ_DONE] & ~rd_status);
         irq_status[`UAB_IRQ_OVF] <= rollover
            | (irq_status[`UAB_IRQ_OVF] & ~rd_status);
         if (accept & req.write & req.address == `UAB_OFF_IRQ_MASK) begin
            irq_mask <= avs_writedata[1:0];
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_status & irq_mask);
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         avs_readdata <= 32'h00000000;
      end else if (avs_waitrequest & avs_read) begin
         unique case (req.address)
            `UAB_OFF_BAUD_CONTROL: avs_readdata <= {24'h000000,
               ctrl.overflow, ~receiver_idle_hold, 1'b0, 1'b0,
               ctrl.wide, 1'b0, ctrl.wake, ctrl.start};
            `UAB_OFF_RECEIVE_HOLDING: avs_readdata <=
               {24'h000000, receive_holding};
            // High byte reading 00h with overflow clear shows the low byte did not overflow
            `UAB_OFF_DIVISOR_LOW: avs_readdata <= {24'h000000, divisor[7:0]};
            `UAB_OFF_DIVISOR_HIGH: avs_readdata <=
               {24'h000000, divisor[15:8]};
            `UAB_OFF_IRQ_STATUS: avs_readdata <= {30'h00000000, irq_status};
            `UAB_OFF_IRQ_MASK: avs_readdata <= {30'h00000000, irq_mask};
            `UAB_OFF_CONFIG: avs_readdata <= {30'h00000000,
               receive_pending_flag, high_speed_divider_select};
            default: avs_readdata <= 32'h00000000;
         endcase
      end
   end
endmodule

// *** sim/uab_sync_sender.sv ***
// Remote sender model: transmits the sync character on the receive line
`timescale 1ns/1ps
module uab_sync_sender (
   input wire logic clock,
   output logic rx_in
);
   initial rx_in = 1'b1;
   // Bit time t in clocks; start bit, data LSB first, stop bit
   task automatic send(input int t);
      logic [9:0] fr = {1'b1, 8'h55, 1'b0};
      for (int i = 0; i < 10; i++) begin
         rx_in <= fr[i];
         repeat (t) @(posedge clock);
      end
   endtask
endmodule

// *** sim/uab_autobaud_props.sv ***
// Port checks of the autobaud block
`timescale 1ns/1ps
`include "uab_cfg.svh"
module uab_autobaud_props #(
   parameter int ADDR_WIDTH = 4
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic [ADDR_WIDTH-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic rx_in,
   input wire logic break_seen,
   input wire logic receiver_idle_hold,
   input wire logic irq
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);
   logic req, arm, hit;
   assign req = avs_read || avs_write;
   assign arm = avs_write && !avs_waitrequest && avs_writedata[0]
      && avs_address == `UAB_OFF_BAUD_CONTROL;
   // Status read or mask write: the only ways software moves irq
   assign hit = !avs_waitrequest
      && (avs_read && avs_address == `UAB_OFF_IRQ_STATUS
      || avs_write && avs_address == `UAB_OFF_IRQ_MASK);
   sequence s_access;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence
   a_wait_low_once: assert property ($rose(req) |=> s_access)
      else $error("waitrequest not low for one cycle");
   a_wait_idle_high: assert property (!req && !$past(req) |->
      avs_waitrequest) else $error("waitrequest low while idle");
   a_arm_holds: assert property (
      arm |-> ##[1:2] receiver_idle_hold)
      else $error("receiver not held after arming");
   a_hold_needs_arm: assert property (
      $rose(receiver_idle_hold) |-> $past(arm) || $past(arm, 2))
      else $error("hold without arming");
   a_fall_keeps_hold: assert property (receiver_idle_hold &&
      $fell(rx_in) |=> receiver_idle_hold) else $error("ended on fall");
   a_end_on_rise: assert property (
      $fell(receiver_idle_hold) |-> rx_in)
      else $error("calibration ended with line low");
   a_irq_rise_cause: assert property ($rose(irq) |->
      $past(receiver_idle_hold, 2) || $past(hit) || $past(hit, 2))
      else $error("irq rose without cause");
   a_irq_drop_cause: assert property ($fell(irq) |->
      $past(hit) || $past(hit, 2)) else $error("irq fell without cause");
endmodule
bind uab_autobaud uab_autobaud_props #(.ADDR_WIDTH(ADDR_WIDTH)) u_props (
   .clock(clock), .resetn(resetn), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .rx_in(rx_in),
   .break_seen(break_seen), .receiver_idle_hold(receiver_idle_hold),
   .irq(irq));

// *** sim/uab_autobaud_detect_bench.sv ***
// Self-checking bench of the autobaud block
`timescale 1ns/1ps
`include "uab_cfg.svh"
module uab_autobaud_detect_bench;
   logic clock, resetn, avs_read, avs_write, avs_waitrequest, break_seen;
   logic rx_in, receiver_idle_hold, irq;
   logic [3:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd;
   int mismatches, n_compared;
   // Bit times give half a tick of margin: 1 + 3 ticks, or 1 + 259
   // Rates chosen to fit each divisor source
   int tb[4] = '{224, 56, 14, 4152};
   logic [15:0] eb[4] = '{16'h0004, 16'h0004, 16'h0004, 16'h0104};
   logic [1:0] mb[4] = '{2'b00, 2'b10, 2'b11, 2'b01};
   uab_autobaud dut (.clock(clock), .resetn(resetn),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .rx_in(rx_in), .break_seen(break_seen),
      .receiver_idle_hold(receiver_idle_hold), .irq(irq));
   uab_sync_sender snd (.clock(clock), .rx_in(rx_in));
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   task automatic check(string what, logic [31:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic access(logic wr, logic [3:0] a, logic [31:0] d);
      int n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge clock);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      rd = avs_readdata;
      if (n >= 50) mismatches++;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clock);
   endtask
   task automatic rchk(logic [3:0] a, logic [31:0] exp);
      access(1'b0, a, 32'h0);
      check($sformatf("reg %0h", a), rd, exp);
   endtask
   task automatic give_verdict;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (80000) @(posedge clock);
      mismatches++;
      give_verdict;
   end
   initial begin
      resetn = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 4'h0;
      avs_writedata = 32'h0;
      break_seen = 1'b0;
      repeat (5) @(posedge clock);
      resetn <= 1'b1;
      @(posedge clock);
      rchk(`UAB_OFF_BAUD_CONTROL, 32'h40);
      for (int i = 0; i < 4; i++) begin
         access(1'b1, `UAB_OFF_CONFIG, {31'h0, mb[i][0]});
         access(1'b1, `UAB_OFF_BAUD_CONTROL, {28'h0, mb[i][1], 3'h0});
         access(1'b1, `UAB_OFF_BAUD_CONTROL, {28'h0, mb[i][1], 3'h1});
         @(posedge clock);
         check("hold", {31'h0, receiver_idle_hold}, 32'h1);
         snd.send(tb[i]);
         // Mask is still clear on the first pass
         check("irq", {31'h0, irq}, {31'h0, i != 0});
         access(1'b1, `UAB_OFF_IRQ_MASK, 32'h3);
         @(posedge clock);
         check("irq", {31'h0, irq}, 32'h1);
         rchk(`UAB_OFF_BAUD_CONTROL, {28'h4, mb[i][1], 3'h0});
         rchk(`UAB_OFF_DIVISOR_LOW, {24'h0, eb[i][7:0]});
         rchk(`UAB_OFF_DIVISOR_HIGH, {24'h0, eb[i][15:8]});
         rchk(`UAB_OFF_CONFIG, {30'h1, mb[i][0]});
         rchk(`UAB_OFF_RECEIVE_HOLDING, {24'h0, `UAB_SYNC_CHAR});
         rchk(`UAB_OFF_CONFIG, {31'h0, mb[i][0]});
         rchk(`UAB_OFF_IRQ_STATUS, 32'h1);
         @(posedge clock);
         check("irq", {31'h0, irq}, 32'h0);
         $display("mode %0d done", i);
      end
      access(1'b1, `UAB_OFF_CONFIG, 32'h1);
      access(1'b1, `UAB_OFF_BAUD_CONTROL, 32'ha);
      access(1'b1, `UAB_OFF_BAUD_CONTROL, 32'hb);
      // Decoy character before the break must not be measured
      snd.send(40);
      check("hold", {31'h0, receiver_idle_hold}, 32'h1);
      break_seen <= 1'b1;
      @(posedge clock);
      break_seen <= 1'b0;
      snd.send(14);
      rchk(`UAB_OFF_DIVISOR_LOW, 32'h4);
      access(1'b1, `UAB_OFF_CONFIG, 32'h1);
      rchk(`UAB_OFF_CONFIG, 32'h3);
      rchk(4'h7, 32'h0);
      $display("wake and access tests done");
      give_verdict;
   end
endmodule
